/* rtl/charge_limit_and_adc_sequencer.sv */
`timescale 1ns/1ps
`include "charge_limit_consts.svh"

module charge_limit_and_adc_sequencer
  import charge_limit_pkg::*;
#(
  parameter int unsigned SLOT_CYCLES    = `SCAN_REVISIT_MS * (`CLK_HZ / 1000) / `NUM_SCAN_CH,
  parameter int unsigned PERIOD1_CYCLES = `PERIOD1_MS * (`CLK_HZ / 1000),
  parameter int unsigned PERIOD2_CYCLES = `PERIOD2_MS * (`CLK_HZ / 1000),
  parameter int unsigned PERIOD3_CYCLES = `PERIOD3_MS * (`CLK_HZ / 1000)
)(
  input  wire logic     CLK_I,
  input  wire logic     RSTN_I,
  input  wire logic [7:0] ADDR_I,
  input  wire word_t    WDATA_I,
  input  wire logic     WR_I,
  input  wire logic     RD_I,
  output word_t         RDATA_O,
  input  wire logic     LOW_POWER_N_I,
  input  wire logic     VIN_PRESENT_I,
  input  wire logic     VIN_UVLO_OK_I,
  input  wire logic     VIN_OVP_I,
  input  wire logic     IN_PRECHARGE_I,
  input  wire logic     IN_COLD_I,
  output adc_req_s      ADC_REQ_O,
  input  wire logic     ADC_DONE_I,
  input  wire word_t    ADC_DATA_I,
  output logic          CHARGE_ENABLE_O,
  output code_t         FAST_CHARGE_CODE_O,
  output code_t         PRECHARGE_CODE_O,
  output code_t         CHARGE_REF_CODE_O,
  output logic          CHARGE_STEP_SELECT_O,
  output logic          IIN_RANGE_HIGH_O,
  output logic          IIN_VALID_O,
  output logic          IRQ_O
);

  // ==========================================================
  // Pin synchronisers
  typedef enum {SEQ_LIMIT_START, SEQ_LIMIT_WAIT, SEQ_IDLE,
                SEQ_CONV_START, SEQ_CONV_WAIT} seq_e;

  logic [3:0]  pin_meta;
  logic [3:0]  pin_sync;
  logic        low_power_n;
  logic        vin_mode;
  logic        uvlo_ok;
  logic        ovp;

  seq_e        state;
  logic [2:0]  chan;
  logic        retry;
  logic        limit_done;
  logic        open_fault;
  code_t       ceiling;
  ctrl_s       ctrl;
  code_t       fast_code;
  code_t       pre_code;
  code_t       cold_code;
  code_t       input_limit;
  logic [2:0]  status;
  logic [2:0]  mask;
  word_t       result [`NUM_SCAN_CH];
  logic [31:0] period_cnt;
  logic [31:0] period_len;
  logic [31:0] slot_cnt;
  logic        auto_pend;
  word_t       rdata;

  logic        wr_status;
  logic        wr_mask;
  logic        wr_ctrl;
  logic        wr_fast;
  logic        wr_pre;
  logic        data_open;
  code_t       ceil_calc;
  logic        limit_meas;
  logic        limit_ok;
  logic        fault_set;
  logic        conv_store;
  logic        scan_last;
  logic        batt_done;
  logic        batt_run;
  logic        period_tick;
  logic        slot_tick;
  code_t       eff_ceil;
  code_t       fast_in;
  code_t       pre_in;
  logic        clamp_ev;
  logic [2:0]  status_set;

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
    end else begin
      pin_meta <= {LOW_POWER_N_I, VIN_PRESENT_I, VIN_UVLO_OK_I, VIN_OVP_I};
      pin_sync <= pin_meta;
    end
  end

  assign low_power_n = pin_sync[3];
  assign vin_mode    = pin_sync[2];
  assign uvlo_ok     = pin_sync[1];
  assign ovp         = pin_sync[0];

  // ==========================================================
  // Decode and derived terms
  assign wr_status = WR_I && (ADDR_I == `REG_STATUS);
  assign wr_mask   = WR_I && (ADDR_I == `REG_MASK);
  assign wr_ctrl   = WR_I && (ADDR_I == `REG_CTRL);
  assign wr_fast   = WR_I && (ADDR_I == `REG_FAST_CODE);
  assign wr_pre    = WR_I && (ADDR_I == `REG_PRE_CODE);

  // Pin sits on a 1.2 V scale, so 2*V/1.2*256 reduces to code >> 7
  assign ceil_calc  = (ADC_DATA_I[15:7] > 9'h0FF) ? 8'hFF : ADC_DATA_I[14:7];
  assign data_open  = ADC_DATA_I > `LIMIT_OPEN_CODE;
  assign limit_meas = (state == SEQ_LIMIT_WAIT) && ADC_DONE_I;
  assign limit_ok   = limit_meas && !data_open;
  assign fault_set  = limit_meas && data_open && retry;

  assign conv_store = (state == SEQ_CONV_WAIT) && ADC_DONE_I;
  assign scan_last  = chan == 3'(`NUM_SCAN_CH - 1);
  // Free-running scans on input power would flood the host
  assign batt_done  = conv_store && scan_last && !vin_mode;

  assign batt_run   = !vin_mode && low_power_n && (ctrl.interval != IVL_MANUAL);

  always_comb begin
    case (ctrl.interval)
      IVL_PERIOD1: period_len = 32'(PERIOD1_CYCLES);
      IVL_PERIOD2: period_len = 32'(PERIOD2_CYCLES);
      IVL_PERIOD3: period_len = 32'(PERIOD3_CYCLES);
      default:     period_len = 32'h1;
    endcase
  end

  assign period_tick = batt_run && (period_cnt >= period_len - 32'h1);
  assign slot_tick   = vin_mode && (slot_cnt >= 32'(SLOT_CYCLES) - 32'h1);

  // ==========================================================
  // Interval timers
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      period_cnt <= 32'h0;
    end else if (!batt_run || period_tick || wr_ctrl) begin
      period_cnt <= 32'h0;
    end else begin
      period_cnt <= period_cnt + 32'h1;
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      slot_cnt <= 32'h0;
    end else if (!vin_mode || slot_tick) begin
      slot_cnt <= 32'h0;
    end else begin
      slot_cnt <= slot_cnt + 32'h1;
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      auto_pend <= 1'b0;
    end else if (period_tick) begin
      auto_pend <= 1'b1;
    end else if (state == SEQ_CONV_START || !batt_run) begin
      auto_pend <= 1'b0;
    end
  end

  // ==========================================================
  // Conversion sequencer
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state      <= SEQ_LIMIT_START;
      chan       <= 3'h0;
      retry      <= 1'b0;
      limit_done <= 1'b0;
      open_fault <= 1'b0;
      ceiling    <= `CEILING_RST;
    end else begin
      case (state)
        SEQ_LIMIT_START: begin
          state <= SEQ_LIMIT_WAIT;
        end
        SEQ_LIMIT_WAIT: begin
          if (ADC_DONE_I) begin
            if (!data_open) begin
              ceiling    <= ceil_calc;
              limit_done <= 1'b1;
              state      <= SEQ_IDLE;
            end else if (!retry) begin
              retry <= 1'b1;
              state <= SEQ_LIMIT_START;
            end else begin
              open_fault <= 1'b1;
              limit_done <= 1'b1;
              state      <= SEQ_IDLE;
            end
          end
        end
        SEQ_IDLE: begin
          if (vin_mode) begin
            if (slot_tick) begin
              state <= SEQ_CONV_START;
            end
          end else if (low_power_n && (ctrl.trigger || auto_pend)) begin
            chan  <= 3'h0;
            state <= SEQ_CONV_START;
          end
        end
        SEQ_CONV_START: begin
          if (!vin_mode && !low_power_n) begin
            chan  <= 3'h0;
            state <= SEQ_IDLE;
          end else begin
            state <= SEQ_CONV_WAIT;
          end
        end
        SEQ_CONV_WAIT: begin
          if (ADC_DONE_I) begin
            if (scan_last) begin
              chan  <= 3'h0;
              state <= SEQ_IDLE;
            end else begin
              chan  <= chan + 3'h1;
              state <= vin_mode ? SEQ_IDLE : SEQ_CONV_START;
            end
          end
        end
        default: begin
          state <= SEQ_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    // On battery, no request once low power is seen, even mid scan; input power and the limit request ignore it
    ADC_REQ_O.start   = (state == SEQ_LIMIT_START) ||
                        ((state == SEQ_CONV_START) && (vin_mode || low_power_n));
    ADC_REQ_O.channel = (state == SEQ_LIMIT_START) ? ADC_CH_LIMIT : adc_chan_e'(chan);
  end

  // ==========================================================
  // Result store, one word per channel
  for (genvar i = 0; i < `NUM_SCAN_CH; i++) begin : g_result
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
        result[i] <= 16'h0000;
      end else if (conv_store && (chan == 3'(i))) begin
        result[i] <= ADC_DATA_I;
      end
    end
  end

  // ==========================================================
  // Fast and pre-charge codes with ceiling clamp
  // Stored fast and pre-charge codes are re-clamped when the ceiling is first learned
  assign eff_ceil = limit_ok ? ceil_calc : ceiling;
  assign fast_in  = wr_fast ? WDATA_I[7:0] : fast_code;
  assign pre_in   = wr_pre ? WDATA_I[7:0] : pre_code;
  assign clamp_ev = (wr_fast || limit_ok) && (fast_in > eff_ceil);

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      fast_code <= `FAST_CODE_RST;
    end else if (wr_fast || limit_ok) begin
      fast_code <= (fast_in > eff_ceil) ? eff_ceil : fast_in;
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pre_code <= `PRE_CODE_RST;
    end else if (wr_pre || limit_ok) begin
      pre_code <= (pre_in > eff_ceil) ? eff_ceil : pre_in;
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cold_code   <= `COLD_CODE_RST;
      input_limit <= `INPUT_LIMIT_RST;
      mask        <= 3'h0;
    end else begin
      if (WR_I && (ADDR_I == `REG_COLD_CODE)) begin
        cold_code <= WDATA_I[7:0];
      end
      if (WR_I && (ADDR_I == `REG_INPUT_LIMIT)) begin
        input_limit <= WDATA_I[7:0];
      end
      if (wr_mask) begin
        mask <= WDATA_I[2:0];
      end
    end
  end

  // ==========================================================
  // Control: interval, trigger, step select
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ctrl <= '{step_select: 1'b0, trigger: 1'b0, interval: IVL_MANUAL};
    end else begin
      if (wr_ctrl) begin
        ctrl.interval    <= interval_e'(WDATA_I[1:0]);
        ctrl.step_select <= WDATA_I[3];
      end
      // Trigger is refused while asleep or on input power
      if (batt_done || vin_mode || !low_power_n) begin
        ctrl.trigger <= 1'b0;
      end else if (wr_ctrl && WDATA_I[2] && (interval_e'(WDATA_I[1:0]) == IVL_MANUAL)) begin
        ctrl.trigger <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Sticky flags and interrupt
  assign status_set = {fault_set, clamp_ev, batt_done};

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      status <= 3'h0;
    end else begin
      // A new event beats a same-cycle clear
      status <= (status & ~(wr_status ? WDATA_I[2:0] : 3'h0)) | status_set;
    end
  end

  assign IRQ_O = |(status & mask);

  // ==========================================================
  // Read port
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rdata <= 16'h0000;
    end else if (!RD_I) begin
      rdata <= 16'h0000;
    end else if ((ADDR_I[7:3] == 5'(`REG_RESULT_BASE >> 3)) && (ADDR_I[2:0] != 3'h7)) begin
      rdata <= result[ADDR_I[2:0]];
    end else begin
      case (ADDR_I)
        `REG_STATUS:      rdata <= {13'h0, status};
        `REG_MASK:        rdata <= {13'h0, mask};
        `REG_CTRL:        rdata <= {12'h0, ctrl.step_select, ctrl.trigger, ctrl.interval};
        `REG_FAST_CODE:   rdata <= {8'h0, fast_code};
        `REG_PRE_CODE:    rdata <= {8'h0, pre_code};
        `REG_COLD_CODE:   rdata <= {8'h0, cold_code};
        `REG_INPUT_LIMIT: rdata <= {8'h0, input_limit};
        `REG_STATE:       rdata <= {10'h0, state != SEQ_IDLE, vin_mode, IIN_VALID_O,
                                    IIN_RANGE_HIGH_O, CHARGE_ENABLE_O, limit_done};
        `REG_CEILING:     rdata <= {8'h0, ceiling};
        default:          rdata <= 16'h0000;
      endcase
    end
  end

  // ==========================================================
  // Outputs
  assign RDATA_O              = rdata;
  assign CHARGE_ENABLE_O      = limit_done && !open_fault;
  assign FAST_CHARGE_CODE_O   = fast_code;
  assign PRECHARGE_CODE_O     = pre_code;
  assign CHARGE_STEP_SELECT_O = ctrl.step_select;
  assign IIN_RANGE_HIGH_O     = input_limit > `INPUT_CURRENT_LIMIT_SMALL_MAX;
  assign IIN_VALID_O          = vin_mode && uvlo_ok && !ovp;
  assign CHARGE_REF_CODE_O    = IN_PRECHARGE_I ? pre_code :
                                (IN_COLD_I ? cold_code : fast_code);

endmodule // charge_limit_and_adc_sequencer

/* rtl/charge_limit_consts.svh */
`ifndef CHARGE_LIMIT_CONSTS_SVH
`define CHARGE_LIMIT_CONSTS_SVH

// ==========================================================
// Register offsets
`define REG_STATUS       8'h00
`define REG_MASK         8'h01
`define REG_CTRL         8'h02
`define REG_FAST_CODE    8'h03
`define REG_PRE_CODE     8'h04
`define REG_COLD_CODE    8'h05
`define REG_INPUT_LIMIT  8'h06
`define REG_STATE        8'h07
`define REG_CEILING      8'h08
`define REG_RESULT_BASE  8'h10

// ==========================================================
// Fields and reset values
`define ST_CONV_DONE     0
`define ST_LIMIT_CLAMP   1
`define ST_OPEN_FAULT    2
`define FAST_CODE_RST    8'h20
`define PRE_CODE_RST     8'h04
`define COLD_CODE_RST    8'h10
`define INPUT_LIMIT_RST  8'h14
`define CEILING_RST      8'hFF
`define INPUT_CURRENT_LIMIT_SMALL_MAX   8'h1E
`define LIMIT_BIAS_UA    80
`define LIMIT_OPEN_CODE  16'hEEEE

// ==========================================================
// Timing
`define CLK_HZ           20000000
`define SCAN_REVISIT_MS  225
`define NUM_SCAN_CH      7
`define PERIOD1_MS       1000
`define PERIOD2_MS       10000
`define PERIOD3_MS       60000
`endif

/* rtl/charge_limit_pkg.sv */
package charge_limit_pkg;
  typedef enum logic [2:0] {ADC_CH_VIN, ADC_CH_IIN, ADC_CH_RAIL, ADC_CH_VBAT,
                            ADC_CH_ICHG, ADC_CH_TS, ADC_CH_AUX, ADC_CH_LIMIT} adc_chan_e;
  typedef struct packed {
    logic      start;
    adc_chan_e channel;
  } adc_req_s;
  typedef enum logic [1:0] {IVL_MANUAL, IVL_PERIOD1, IVL_PERIOD2, IVL_PERIOD3} interval_e;
  typedef struct packed {
    logic      step_select;
    logic      trigger;
    interval_e interval;
  } ctrl_s;
  typedef logic [7:0]  code_t;
  typedef logic [15:0] word_t;
endpackage

/* testbench/adc_model.sv */
`timescale 1ns/1ps
module adc_model
  import charge_limit_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire adc_req_s   req_i,
  input  wire word_t      lim_first_i,
  input  wire word_t      lim_second_i,
  input  wire logic [3:0] lat_i,
  output logic            done_o,
  output word_t           data_o,
  output int              n_limit_o
);
  logic       busy;
  logic [3:0] cnt;
  adc_chan_e  ch;
  // ==========================================================
  // Conversion engine
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy <= 1'b0;
      cnt <= 4'h0;
      ch <= ADC_CH_LIMIT;
      done_o <= 1'b0;
      data_o <= 16'h0000;
      n_limit_o <= 0;
    end else begin
      done_o <= 1'b0;
      // Idle bus toggles so stale data never looks valid
      data_o <= ~data_o;
      if (req_i.start) begin
        busy <= 1'b1;
        cnt <= lat_i;
        ch <= req_i.channel;
      end else if (busy && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (busy) begin
        busy <= 1'b0;
        done_o <= 1'b1;
        if (ch == ADC_CH_LIMIT) begin
          data_o <= (n_limit_o == 0) ? lim_first_i : lim_second_i;
          n_limit_o <= n_limit_o + 1;
        end else begin
          data_o <= {4'hC, 1'b0, ch, 8'h35};
        end
      end
    end
  end
endmodule // adc_model

/* testbench/charge_limit_and_adc_sequencer_tb.sv */
`timescale 1ns/1ps
`include "charge_limit_consts.svh"
module charge_limit_and_adc_sequencer_tb
  import charge_limit_pkg::*;
;
  logic       clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, lp_n = 1'b1;
  logic       vin = 1'b0, uvlo_ok = 1'b0, ovp = 1'b0, pre = 1'b0, cold = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [3:0] lat = 4'h2;
  word_t      wdata = 16'h0000, lim1 = 16'h1900, lim2 = 16'h1900;
  word_t      rdata, adc_data;
  adc_req_s   req;
  logic       done, en, step, rng, ivalid, irq;
  code_t      fast, prec, ref_code;
  int         n_lim, cyc = 0, err_total = 0, n_checks = 0;

  charge_limit_and_adc_sequencer #(.SLOT_CYCLES(8), .PERIOD1_CYCLES(20),
    .PERIOD2_CYCLES(40), .PERIOD3_CYCLES(60)) dut (
    .CLK_I(clk), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .LOW_POWER_N_I(lp_n), .VIN_PRESENT_I(vin), .VIN_UVLO_OK_I(uvlo_ok),
    .VIN_OVP_I(ovp), .IN_PRECHARGE_I(pre), .IN_COLD_I(cold), .ADC_REQ_O(req),
    .ADC_DONE_I(done), .ADC_DATA_I(adc_data), .CHARGE_ENABLE_O(en),
    .FAST_CHARGE_CODE_O(fast), .PRECHARGE_CODE_O(prec), .CHARGE_REF_CODE_O(ref_code),
    .CHARGE_STEP_SELECT_O(step), .IIN_RANGE_HIGH_O(rng), .IIN_VALID_O(ivalid), .IRQ_O(irq));
  adc_model u_adc (.clk_i(clk), .rstn_i(rstn), .req_i(req), .lim_first_i(lim1),
    .lim_second_i(lim2), .lat_i(lat), .done_o(done), .data_o(adc_data), .n_limit_o(n_lim));

  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  // ==========================================================
  // Shared tasks
  task automatic chk(input string what, input word_t seen, input word_t exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input word_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input word_t exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(what, rdata, exp);
  endtask
  task automatic reset_dut(input word_t a, input word_t b, input int need);
    @(posedge clk);
    rstn <= 1'b0;
    lim1 <= a;
    lim2 <= b;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    for (int k = 0; k < 100 && n_lim < need; k++)
      @(posedge clk);
    repeat (4) @(posedge clk);
  endtask
  task automatic wait_start(output adc_chan_e ch, output int t);
    ch = ADC_CH_LIMIT;
    t = 0;
    for (int k = 0; k < 80 && ch == ADC_CH_LIMIT; k++) begin
      @(posedge clk);
      #1;
      if (req.start === 1'b1)
        ch = req.channel;
      t = cyc;
    end
  endtask
  task automatic count_starts(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (req.start === 1'b1 && req.channel == ADC_CH_VIN)
        c++;
    end
  endtask
  task automatic t_scan(input logic [3:0] l);
    adc_chan_e ch;
    int t;
    lat <= l;
    wr_reg(`REG_CTRL, 16'h0004);
    for (int i = 0; i < 7; i++) begin
      wait_start(ch, t);
      chk("scan channel", 16'(ch), 16'(i));
    end
    repeat (l + 4) @(posedge clk);
    #1;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_open();
    reset_dut(16'hEEEE, 16'hF000, 1);
    rchk("edge ceiling", `REG_CEILING, 16'h00FF);
    chk("edge count", 16'(n_lim), 16'h0001);
    reset_dut(16'hF000, 16'h1900, 2);
    chk("retry enable", 16'(en), 16'h0001);
    rchk("retry ceiling", `REG_CEILING, 16'h0032);
    reset_dut(16'hF000, 16'hF000, 2);
    repeat (50) @(posedge clk);
    chk("open enable", 16'(en), 16'h0000);
    chk("open count", 16'(n_lim), 16'h0002);
    rchk("open flag", `REG_STATUS, 16'h0004);
  endtask
  task automatic t_limit();
    reset_dut(16'h1900, 16'h1900, 1);
    rchk("ceiling", `REG_CEILING, 16'h0032);
    chk("enable", 16'(en), 16'h0001);
    chk("limit count", 16'(n_lim), 16'h0001);
    rchk("state bits", `REG_STATE, 16'h0003);
    rchk("cold code", `REG_COLD_CODE, 16'h0010);
    rchk("unmapped", 8'h3F, 16'h0000);
  endtask
  task automatic t_clamp();
    wr_reg(`REG_FAST_CODE, 16'h0040);
    rchk("fast clamp", `REG_FAST_CODE, 16'h0032);
    chk("fast out", 16'(fast), 16'h0032);
    rchk("clamp flag", `REG_STATUS, 16'h0002);
    wr_reg(`REG_STATUS, 16'h0002);
    wr_reg(`REG_FAST_CODE, 16'h0032);
    rchk("no clamp", `REG_STATUS, 16'h0000);
    wr_reg(`REG_PRE_CODE, 16'h0040);
    rchk("pre clamp", `REG_PRE_CODE, 16'h0032);
    chk("pre out", 16'(prec), 16'h0032);
    rchk("pre no flag", `REG_STATUS, 16'h0000);
    wr_reg(`REG_CTRL, 16'h0008);
    chk("step", 16'(step), 16'h0001);
    rchk("ctrl read", `REG_CTRL, 16'h0008);
    wr_reg(`REG_FAST_CODE, 16'h0033);
    rchk("step clamp", `REG_FAST_CODE, 16'h0032);
    wr_reg(`REG_STATUS, 16'h0002);
    wr_reg(`REG_CTRL, 16'h0000);
  endtask
  task automatic t_ref();
    wr_reg(`REG_PRE_CODE, 16'h0005);
    @(posedge clk);
    pre <= 1'b1;
    #1 chk("ref pre", 16'(ref_code), 16'h0005);
    @(posedge clk);
    pre <= 1'b0;
    cold <= 1'b1;
    #1 chk("ref cold", 16'(ref_code), 16'h0010);
    @(posedge clk);
    cold <= 1'b0;
    #1 chk("ref fast", 16'(ref_code), 16'h0032);
  endtask
  task automatic t_manual();
    int c;
    wr_reg(`REG_MASK, 16'h0001);
    count_starts(40, c);
    chk("idle starts", 16'(c), 16'h0000);
    t_scan(4'h5);
    rchk("done flag", `REG_STATUS, 16'h0001);
    chk("irq", 16'(irq), 16'h0001);
    for (int i = 0; i < 7; i++)
      rchk("result", 8'(`REG_RESULT_BASE + i), 16'(16'hC035 | (i << 8)));
    wr_reg(`REG_STATUS, 16'h0001);
    chk("irq clear", 16'(irq), 16'h0000);
    wr_reg(`REG_MASK, 16'h0000);
    t_scan(4'h0);
    chk("masked irq", 16'(irq), 16'h0000);
    wr_reg(`REG_MASK, 16'h0001);
    chk("unmasked irq", 16'(irq), 16'h0001);
    wr_reg(`REG_STATUS, 16'h0001);
  endtask
  task automatic t_lowpower();
    int c;
    @(posedge clk);
    lp_n <= 1'b0;
    repeat (3) @(posedge clk);
    wr_reg(`REG_CTRL, 16'h0004);
    count_starts(60, c);
    chk("low power starts", 16'(c), 16'h0000);
    @(posedge clk);
    lp_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_scan(4'h1);
    rchk("wake flag", `REG_STATUS, 16'h0001);
  endtask
  task automatic t_periodic();
    int c;
    for (int k = 1; k < 4; k++) begin
      wr_reg(`REG_CTRL, 16'(k));
      count_starts(300, c);
      chk("scan count", 16'(c >= 2 && c <= 300 / (20 * k) + 1), 16'h0001);
    end
    wr_reg(`REG_CTRL, 16'h0000);
    repeat (40) @(posedge clk);
  endtask
  task automatic t_vin();
    adc_chan_e c0, c;
    int t, tp;
    @(posedge clk);
    vin <= 1'b1;
    uvlo_ok <= 1'b1;
    lat <= 4'h0;
    repeat (40) @(posedge clk);
    wr_reg(`REG_STATUS, 16'h0007);
    wait_start(c0, tp);
    for (int i = 1; i < 15; i++) begin
      wait_start(c, t);
      chk("slot channel", 16'(c), 16'((c0 + i) % 7));
      chk("slot gap", 16'(t - tp), 16'h0008);
      tp = t;
    end
    chk("vin irq", 16'(irq), 16'h0000);
    rchk("vin status", `REG_STATUS, 16'h0000);
    chk("iin valid", 16'(ivalid), 16'h0001);
    @(posedge clk);
    ovp <= 1'b1;
    repeat (3) @(posedge clk);
    chk("iin invalid", 16'(ivalid), 16'h0000);
    rchk("ovp result", 8'h13, 16'hC335);
    wr_reg(`REG_INPUT_LIMIT, 16'h001E);
    chk("small range", 16'(rng), 16'h0000);
    wr_reg(`REG_INPUT_LIMIT, 16'h001F);
    chk("large range", 16'(rng), 16'h0001);
    rchk("limit read", `REG_INPUT_LIMIT, 16'h001F);
  endtask
  // ==========================================================
  // Run control
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    t_open();
    t_limit();
    t_clamp();
    t_ref();
    t_manual();
    t_lowpower();
    t_periodic();
    t_vin();
    tally_and_finish();
  end
  // Whole run is a few thousand cycles; this leaves a wide margin
  initial begin
    #(50 * 20000);
    err_total++;
    tally_and_finish();
  end
endmodule // charge_limit_and_adc_sequencer_tb

/* testbench/charge_limit_assertions.sv */
`timescale 1ns/1ps
module charge_limit_checker
  import charge_limit_pkg::*;
(
  input wire logic     CLK_I,
  input wire logic     RSTN_I,
  input wire logic     WR_I,
  input wire logic     RD_I,
  input wire word_t    RDATA_O,
  input wire logic     IN_PRECHARGE_I,
  input wire logic     IN_COLD_I,
  input wire adc_req_s ADC_REQ_O,
  input wire logic     ADC_DONE_I,
  input wire logic     CHARGE_ENABLE_O,
  input wire code_t    FAST_CHARGE_CODE_O,
  input wire code_t    PRECHARGE_CODE_O,
  input wire code_t    CHARGE_REF_CODE_O,
  input wire logic     IRQ_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  // ==========================================================
  // Properties
  property p_first_req;
    $rose(RSTN_I) |-> ADC_REQ_O.start && ADC_REQ_O.channel == ADC_CH_LIMIT ##1 !ADC_REQ_O.start;
  endproperty
  a_first_req: assert property (p_first_req)
    else $error("limit request not issued once after reset");
  property p_req_pulse;
    ADC_REQ_O.start |=> !ADC_REQ_O.start;
  endproperty
  a_req_pulse: assert property (p_req_pulse)
    else $error("conversion request longer than one cycle");
  property p_irq_cause;
    $rose(IRQ_O) |-> $past(ADC_DONE_I) || $past(WR_I);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt rose without a conversion or write");
  property p_rdata_idle;
    !$past(RD_I) |-> RDATA_O == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside read answer");
  property p_ref_pre;
    IN_PRECHARGE_I |-> CHARGE_REF_CODE_O == PRECHARGE_CODE_O;
  endproperty
  a_ref_pre: assert property (p_ref_pre)
    else $error("reference not pre-charge code");
  property p_ref_fast;
    !IN_PRECHARGE_I && !IN_COLD_I |-> CHARGE_REF_CODE_O == FAST_CHARGE_CODE_O;
  endproperty
  a_ref_fast: assert property (p_ref_fast)
    else $error("reference not fast code");
  property p_enable_hold;
    CHARGE_ENABLE_O |=> CHARGE_ENABLE_O;
  endproperty
  a_enable_hold: assert property (p_enable_hold)
    else $error("charge enable dropped without reset");
  property p_enable_cause;
    $rose(CHARGE_ENABLE_O) |-> $past(ADC_DONE_I);
  endproperty
  a_enable_cause: assert property (p_enable_cause)
    else $error("charge enabled without limit measurement");
  c_irq: cover property ($rose(IRQ_O));
  c_enable: cover property ($rose(CHARGE_ENABLE_O));
  c_aux: cover property (ADC_REQ_O.start && ADC_REQ_O.channel == ADC_CH_AUX);
endmodule // charge_limit_checker

bind charge_limit_and_adc_sequencer charge_limit_checker u_chk (
  .CLK_I(CLK_I), .RSTN_I(RSTN_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .IN_PRECHARGE_I(IN_PRECHARGE_I), .IN_COLD_I(IN_COLD_I), .ADC_REQ_O(ADC_REQ_O),
  .ADC_DONE_I(ADC_DONE_I), .CHARGE_ENABLE_O(CHARGE_ENABLE_O),
  .FAST_CHARGE_CODE_O(FAST_CHARGE_CODE_O), .PRECHARGE_CODE_O(PRECHARGE_CODE_O),
  .CHARGE_REF_CODE_O(CHARGE_REF_CODE_O), .IRQ_O(IRQ_O));
